// file: src/rst_sup_pkg.sv
// constants and types for the reset supervisor
package rst_sup_pkg;
   localparam int          CLK_PERIOD_NS   = 40;
   localparam int          FILTER_TIME_NS  = 10000;  // reset filter time
   localparam int          FILTER_CYCLES   =
      (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          EXT_DELAY_US    = 10000;  // extended release delay
   localparam int          RED_DELAY_US    = 2000;   // reduced release delay
   localparam int          EXT_DELAY_CYCLES = EXT_DELAY_US * 1000 / CLK_PERIOD_NS;
   localparam int          RED_DELAY_CYCLES = RED_DELAY_US * 1000 / CLK_PERIOD_NS;
   localparam int          DELAY_W         = 20;
   localparam logic [1:0]  SOFT_RESET_CODE = 2'h3;
   localparam logic [1:0]  THRESH_DEFAULT  = 2'h0;   // first falling level
   localparam logic [1:0]  WATCHDOG_FAIL_COUNT_MAX     = 2'h2;
   typedef enum logic [4:0] {
      MODE_INIT     = 5'h01,
      MODE_NORMAL   = 5'h02,
      MODE_STOP     = 5'h04,
      MODE_RESTART  = 5'h08,
      MODE_FAILSAFE = 5'h10
   } mode_type;
endpackage : rst_sup_pkg

// file: src/event_filter.sv
// qualifies a raw level: output follows only after it held for n cycles
`timescale 1ns/1ps
module event_filter #(
   parameter int N = 250
) (
   input  wire logic clk,   // system clock
   input  wire logic rst_b, // async reset, active low
   input  wire logic raw,   // unfiltered event level
   output logic      qual   // filtered level
);
   logic [15:0] count;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 16'h0;
         qual  <= 1'b0;
      end else if (raw == qual) begin
         count <= 16'h0;
      end else if (count >= 16'(N - 1)) begin
         count <= 16'h0;
         qual  <= raw;
      end else begin
         count <= count + 16'h1;
      end
   end
endmodule : event_filter

// file: src/reset_supervisor.sv
// reset output supervision with soft reset and watchdog fail handling
`timescale 1ns/1ps
// Notes on behaviour
// - reset event drives output low, undervoltage only after filter, held until delay ends
// - release delay is extended by default, reduced when select bit set
// - at power-up output stays low, released after extended delay
// - watchdog failure is a reset event like undervoltage
// - undervoltage threshold selectable by host, first level by default
// - soft reset returns to init mode and restores all defaults, except a fail count stepped by a watchdog failure in the same cycle
// - option bit 0: soft reset also pulses output, extended delay
// - option bit 1: soft reset leaves output high, internal reset only
// - soft reset accepted only in normal or stop mode, else ignored
// - watchdog reset enters restart or fail-safe and counts failures
module reset_supervisor
   import rst_sup_pkg::*;
#(
   parameter int EXT_DELAY = EXT_DELAY_CYCLES,
   parameter int RED_DELAY = RED_DELAY_CYCLES,
   parameter int FILTER    = FILTER_CYCLES
) (
   input  wire logic              CLK_SYS,        // 25 MHz clock
   input  wire logic              RST_B,          // power-on reset, low
   input  wire logic              UV_LEVEL_1,     // below threshold 1
   input  wire logic              UV_LEVEL_2,     // below threshold 2
   input  wire logic              UV_LEVEL_3,     // below threshold 3
   input  wire logic              UV_LEVEL_4,     // below threshold 4
   input  wire logic              WD_FAILURE,     // watchdog fail pulse
   input  wire logic              CMD_VALID,      // host command strobe
   input  wire logic [1:0]        CMD_MODE,       // requested mode field
   input  wire logic              CMD_THRESH_WR,  // threshold write strobe
   input  wire logic [1:0]        CMD_THRESH,     // threshold select
   input  wire logic              CMD_CFG_WR,     // option bits write strobe
   input  wire logic              CMD_DELAY_SEL,  // reset_delay_select value
   input  wire logic              CMD_SOFT_NOPIN, // soft reset skips pin
   input  wire logic              CFG_FAILSAFE,   // watchdog failure goes fail-safe, not restart
   output logic                   RESET_OUTPUT_LOW_ACTIVE, // reset pin, low
   output rst_sup_pkg::mode_type  MODE,           // operating mode
   output logic [1:0]             THRESH_SEL,     // active threshold
   output logic                   RESET_DELAY_SELECT, // reduced delay on
   output logic                   SOFT_RESET_NOPIN,   // option bit state
   output logic [1:0]             WATCHDOG_FAIL_COUNT, // failure counter
   output logic                   SOFT_RESET_DONE // one-cycle internal reset
);
   logic                uv_raw;
   logic                uv_qual;
   logic                soft_req;
   logic                soft_pin;
   logic                reset_req;
   logic                req_q;
   logic [DELAY_W-1:0]  delay_cnt;
   logic [DELAY_W-1:0]  delay_len;
   logic                delay_ext;

   // threshold choice only matters while comparators are valid
   always_comb begin
      unique case (THRESH_SEL)
         2'h0: uv_raw = UV_LEVEL_1;
         2'h1: uv_raw = UV_LEVEL_2;
         2'h2: uv_raw = UV_LEVEL_3;
         default: uv_raw = UV_LEVEL_4;
      endcase
   end

   event_filter #(.N(FILTER)) uv_filter (
      .clk   (CLK_SYS),
      .rst_b (RST_B),
      .raw   (uv_raw),
      .qual  (uv_qual)
   );

   assign soft_req = CMD_VALID && CMD_MODE == SOFT_RESET_CODE &&
                     (MODE == MODE_NORMAL || MODE == MODE_STOP);
   assign soft_pin = soft_req && !SOFT_RESET_NOPIN;
   assign reset_req = uv_qual || WD_FAILURE || soft_pin;

   // soft reset and watchdog reset count only as mode changes here
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         MODE <= MODE_INIT;
      end else if (soft_req) begin
         MODE <= MODE_INIT;
      end else if (WD_FAILURE) begin
         MODE <= CFG_FAILSAFE ? MODE_FAILSAFE : MODE_RESTART;
      end else if (CMD_VALID && CMD_MODE == 2'h0 && MODE != MODE_FAILSAFE) begin
         MODE <= MODE_NORMAL;
      end else if (CMD_VALID && CMD_MODE == 2'h1 && MODE == MODE_NORMAL) begin
         MODE <= MODE_STOP;
      end else if (MODE == MODE_RESTART && RESET_OUTPUT_LOW_ACTIVE) begin
         MODE <= MODE_NORMAL;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         THRESH_SEL         <= THRESH_DEFAULT;
         RESET_DELAY_SELECT <= 1'b0;
         SOFT_RESET_NOPIN   <= 1'b0;
      end else if (soft_req) begin
         THRESH_SEL         <= THRESH_DEFAULT;
         RESET_DELAY_SELECT <= 1'b0;
         SOFT_RESET_NOPIN   <= 1'b0;
      end else begin
         if (CMD_THRESH_WR)
            THRESH_SEL <= CMD_THRESH;
         if (CMD_CFG_WR) begin
            RESET_DELAY_SELECT <= CMD_DELAY_SEL;
            SOFT_RESET_NOPIN   <= CMD_SOFT_NOPIN;
         end
      end
   end

   // saturating fail counter; a soft reset clears it unless a counting watchdog failure comes in the same cycle
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B)
         WATCHDOG_FAIL_COUNT <= 2'h0;
      else if (WD_FAILURE && WATCHDOG_FAIL_COUNT != WATCHDOG_FAIL_COUNT_MAX)
         WATCHDOG_FAIL_COUNT <= WATCHDOG_FAIL_COUNT + 2'h1;
      else if (soft_req)
         WATCHDOG_FAIL_COUNT <= 2'h0;
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B)
         SOFT_RESET_DONE <= 1'b0;
      else
         SOFT_RESET_DONE <= soft_req;
   end

   // power-up and soft reset use the extended delay regardless of select
   assign delay_len = delay_ext ? DELAY_W'(EXT_DELAY)
                      : (RESET_DELAY_SELECT ? DELAY_W'(RED_DELAY)
                                            : DELAY_W'(EXT_DELAY));

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         req_q     <= 1'b1;
         delay_ext <= 1'b1;
      end else begin
         req_q <= reset_req;
         if (soft_pin)
            delay_ext <= 1'b1;
         else if (reset_req)
            delay_ext <= 1'b0;
         else if (RESET_OUTPUT_LOW_ACTIVE)
            delay_ext <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         delay_cnt               <= '0;
         RESET_OUTPUT_LOW_ACTIVE <= 1'b0;
      end else if (reset_req || req_q) begin
         delay_cnt               <= '0;
         RESET_OUTPUT_LOW_ACTIVE <= 1'b0;
      end else if (!RESET_OUTPUT_LOW_ACTIVE) begin
         if (delay_cnt >= delay_len - DELAY_W'(1))
            RESET_OUTPUT_LOW_ACTIVE <= 1'b1;
         else
            delay_cnt <= delay_cnt + DELAY_W'(1);
      end
   end

   // pin behaviour: assert, hold and release
   a_wd_pulls_low: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      WD_FAILURE |=> !RESET_OUTPUT_LOW_ACTIVE)
      else $error("watchdog failure did not assert reset");
   a_uv_holds_low: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      uv_qual |=> !RESET_OUTPUT_LOW_ACTIVE)
      else $error("reset released during undervoltage");
   a_release_delay: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      $rose(RESET_OUTPUT_LOW_ACTIVE) |->
      $past(delay_cnt) == $past(delay_len) - DELAY_W'(1))
      else $error("reset released before delay expired");
   a_reduced_delay: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      (reset_req && !soft_pin) ##1 RESET_DELAY_SELECT |->
      delay_len == DELAY_W'(RED_DELAY))
      else $error("reduced delay not used after event");

   // soft reset handling
   a_soft_mode_init: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      soft_req |=> MODE == MODE_INIT && THRESH_SEL == THRESH_DEFAULT)
      else $error("soft reset did not restore defaults");
   a_soft_cfg_clear: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      soft_req |=> !RESET_DELAY_SELECT && !SOFT_RESET_NOPIN &&
      SOFT_RESET_DONE)
      else $error("soft reset left option bits set");
   a_soft_pin_on: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      soft_req && !SOFT_RESET_NOPIN |=> !RESET_OUTPUT_LOW_ACTIVE)
      else $error("soft reset did not pulse reset pin");
   a_soft_ext_delay: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      soft_pin |=> delay_ext)
      else $error("pin soft reset did not pick extended delay");
   a_soft_pin_off: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      (soft_req && SOFT_RESET_NOPIN && !uv_qual && !WD_FAILURE &&
      RESET_OUTPUT_LOW_ACTIVE && !req_q) |=> RESET_OUTPUT_LOW_ACTIVE)
      else $error("soft reset without pin option pulled reset");
   a_soft_ignored: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      (CMD_VALID && CMD_MODE == SOFT_RESET_CODE && MODE != MODE_NORMAL &&
      MODE != MODE_STOP) |=> !SOFT_RESET_DONE)
      else $error("soft reset accepted outside normal or stop");

   // watchdog failure handling and settings
   a_wd_mode: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      (WD_FAILURE && !soft_req) |=>
      (MODE == MODE_RESTART || MODE == MODE_FAILSAFE))
      else $error("watchdog failure mode wrong");
   a_wd_count_step: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      (WD_FAILURE && WATCHDOG_FAIL_COUNT != WATCHDOG_FAIL_COUNT_MAX) |=>
      WATCHDOG_FAIL_COUNT == $past(WATCHDOG_FAIL_COUNT) + 2'h1)
      else $error("watchdog fail count did not step");
   a_wd_count_cap: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      WATCHDOG_FAIL_COUNT <= WATCHDOG_FAIL_COUNT_MAX)
      else $error("watchdog fail count above its ceiling");
   a_thresh_write: assert property (@(posedge CLK_SYS)
      disable iff (!RST_B)
      (CMD_THRESH_WR && !soft_req) |=> THRESH_SEL == $past(CMD_THRESH))
      else $error("threshold select not taken");
endmodule : reset_supervisor

// file: bench/host_model.sv
// host side model issuing mode commands toward the supervisor
`timescale 1ns/1ps
module host_model
   import rst_sup_pkg::*;
(
   input  wire logic                 CLK_SYS,   // system clock
   input  wire rst_sup_pkg::mode_type MODE,     // device mode
   output logic                      CMD_VALID, // command strobe
   output logic [1:0]                CMD_MODE   // mode field
);
   initial begin
      CMD_VALID = 1'b0;
      CMD_MODE  = 2'h2;
   end
   // called just after an edge; anyway skips the polite mode check
   task automatic send(input logic [1:0] m, input bit anyway);
      if (m == SOFT_RESET_CODE && !anyway &&
          !(MODE inside {MODE_NORMAL, MODE_STOP})) return;
      CMD_VALID = 1'b1;
      CMD_MODE  = m;
      @(posedge CLK_SYS);
      #1;
      CMD_VALID = 1'b0;
      // idle field differs from the last so a stale value is not reused
      CMD_MODE  = ~m;
   endtask : send
endmodule : host_model

// file: bench/reset_supervisor_tb.sv
// self-checking bench for the reset supervisor
`timescale 1ns/1ps
module reset_supervisor_tb;
   import rst_sup_pkg::*;
   localparam int EXT = 20;
   localparam int RED = 8;
   localparam int FLT = 3;
   logic       clk, pin, dsel_o, nopin_o, done, cv, last_pin = 1'b0;
   logic       rst_b = 1'b0, fs = 1'b0, wd = 1'b0, twr = 1'b0;
   logic       cwr = 1'b0, dsel = 1'b0, nopin = 1'b0;
   logic [1:0] thr = 2'h0, thr_o, wdc, cm;
   logic [31:0] lfsr = 32'h2ef3;
   mode_type   mode, last_mode = MODE_INIT, mode_q[$];
   logic       pin_lv[$];
   int         pin_t[$], mode_t[$], cyc = 0, miscompares = 0, checks_done = 0;
   logic [3:0] uvl = 4'h0;
   reset_supervisor #(.EXT_DELAY(EXT), .RED_DELAY(RED), .FILTER(FLT)) dut (
      .CLK_SYS(clk), .RST_B(rst_b), .UV_LEVEL_1(uvl[0]), .UV_LEVEL_2(uvl[1]),
      .UV_LEVEL_3(uvl[2]), .UV_LEVEL_4(uvl[3]), .WD_FAILURE(wd),
      .CMD_VALID(cv), .CMD_MODE(cm), .CMD_THRESH_WR(twr), .CMD_THRESH(thr),
      .CMD_CFG_WR(cwr), .CMD_DELAY_SEL(dsel), .CMD_SOFT_NOPIN(nopin),
      .CFG_FAILSAFE(fs),
      .RESET_OUTPUT_LOW_ACTIVE(pin), .MODE(mode), .THRESH_SEL(thr_o),
      .RESET_DELAY_SELECT(dsel_o), .SOFT_RESET_NOPIN(nopin_o),
      .WATCHDOG_FAIL_COUNT(wdc), .SOFT_RESET_DONE(done));
   host_model host (.CLK_SYS(clk), .MODE(mode), .CMD_VALID(cv),
      .CMD_MODE(cm));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic stop_test();
      miscompares += pin_t.size() + mode_t.size();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [1:0] e, logic [1:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %0h seen %0h", n, e, g);
      end
   endtask : chk
   // times are exact: every path is a fixed count of register stages
   task automatic cmp_time(input string n, input int e, input int g);
      checks_done++;
      if (g != e) begin
         miscompares++;
         $display("unexpected %s: expected %0d seen %0d", n, e, g);
      end
   endtask : cmp_time
   task automatic cmp_mode(input mode_type e, input mode_type g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected mode: expected %0h seen %0h", e, g);
      end
   endtask : cmp_mode
   always @(posedge clk) begin
      #2;
      if (pin !== last_pin) begin
         last_pin = pin;
         if (pin_t.size() == 0) chk("pin change", 2'h0, 2'h1);
         else begin
            chk("pin", {1'b0, pin_lv.pop_front()}, {1'b0, pin});
            cmp_time("pin time", pin_t.pop_front(), cyc);
         end
      end
      if (mode !== last_mode) begin
         if (mode_t.size() == 0) chk("mode change", 2'h0, 2'h1);
         else begin
            cmp_mode(mode_q.pop_front(), mode);
            cmp_time("mode time", mode_t.pop_front(), cyc);
         end
      end
      last_mode = mode;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic exp_pin(input logic lv, input int t);
      pin_lv.push_back(lv);
      pin_t.push_back(cyc + t);
   endtask : exp_pin
   task automatic exp_mode(input mode_type m, input int t);
      mode_q.push_back(m);
      mode_t.push_back(cyc + t);
   endtask : exp_mode
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   task automatic set_cfg(input logic d, input logic n);
      cwr = 1'b1;
      dsel = d;
      nopin = n;
      step(1);
      cwr = 1'b0;
   endtask : set_cfg
   initial begin
      step(6);
      rst_b = 1'b1;
      exp_pin(1'b1, EXT + 1);
      step(EXT + 4);
      chk("threshold", THRESH_DEFAULT, thr_o);
      chk("delay select", 2'h0, {1'b0, dsel_o});
      exp_mode(MODE_NORMAL, 1);
      host.send(2'h0, 0);
      lfsr = next_rand(lfsr);
      twr = 1'b1;
      thr = lfsr[1:0];
      step(1);
      twr = 1'b0;
      chk("threshold", lfsr[1:0], thr_o);
      // every level but the selected one is high: the pin must not move
      uvl = ~(4'h1 << lfsr[1:0]);
      step(FLT + 3);
      uvl = 4'h0;
      chk("pin unselected level", 2'h1, {1'b0, pin});
      exp_mode(MODE_INIT, 1);
      exp_pin(1'b0, 1);
      exp_pin(1'b1, EXT + 2);
      host.send(SOFT_RESET_CODE, 0);
      chk("threshold", THRESH_DEFAULT, thr_o);
      chk("soft reset done", 2'h1, {1'b0, done});
      step(EXT + 4);
      host.send(SOFT_RESET_CODE, 1);
      chk("soft reset done", 2'h0, {1'b0, done});
      step(4);
      exp_mode(MODE_NORMAL, 1);
      host.send(2'h0, 0);
      set_cfg(1'b1, 1'b1);
      exp_mode(MODE_STOP, 1);
      host.send(2'h1, 0);
      step(1);
      exp_mode(MODE_INIT, 1);
      host.send(SOFT_RESET_CODE, 0);
      chk("delay select", 2'h0, {1'b0, dsel_o});
      chk("pin option", 2'h0, {1'b0, nopin_o});
      chk("soft reset done", 2'h1, {1'b0, done});
      step(EXT + 4);
      exp_mode(MODE_NORMAL, 1);
      host.send(2'h0, 0);
      set_cfg(1'b1, 1'b0);
      exp_pin(1'b0, 1);
      exp_mode(MODE_RESTART, 1);
      exp_pin(1'b1, RED + 2);
      exp_mode(MODE_NORMAL, RED + 3);
      wd = 1'b1;
      step(1);
      wd = 1'b0;
      chk("watchdog_fail_count count", 2'h1, wdc);
      step(RED + 4);
      // a pulse one cycle short of the filter time is dropped
      uvl[0] = 1'b1;
      step(FLT - 1);
      uvl[0] = 1'b0;
      step(4);
      exp_pin(1'b0, FLT + 1);
      uvl[0] = 1'b1;
      step(10);
      uvl[0] = 1'b0;
      step(5);
      exp_pin(1'b1, RED + 2);
      exp_mode(MODE_FAILSAFE, 1);
      fs = 1'b1;
      wd = 1'b1;
      step(1);
      wd = 1'b0;
      chk("watchdog_fail_count count", WATCHDOG_FAIL_COUNT_MAX, wdc);
      step(RED + 6);
      // a further failure keeps the count at its ceiling
      exp_pin(1'b0, 1);
      exp_pin(1'b1, RED + 2);
      wd = 1'b1;
      step(1);
      wd = 1'b0;
      chk("watchdog_fail_count count", WATCHDOG_FAIL_COUNT_MAX, wdc);
      step(RED + 4);
      stop_test();
   end
endmodule : reset_supervisor_tb
